/* ulf_pkg.sv */
// Purpose: Shared constants for the line format and status serial channel
// Assumes: 8-bit register bus, 16x oversampled bit timing
// Notes:   Offsets, field positions, reset values and counts live here
package ulf_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFS_DATA = 3'h0;   // Receive/transmit holding or divisor low
    localparam logic [2:0] OFS_DIVH = 3'h1;   // Divisor high while divisor access is on
    localparam logic [2:0] OFS_LFC = 3'h3;    // line_format_control
    localparam logic [2:0] OFS_LCS = 3'h5;    // line_condition_status

    // ----------------------------------------
    // line_format_control fields
    // ----------------------------------------
    localparam int LFC_DIV_ACCESS = 7;
    localparam int LFC_BREAK = 6;
    localparam int LFC_FORCE_PAR = 5;
    localparam int LFC_EVEN_PAR = 4;
    localparam int LFC_PAR_EN = 3;
    localparam int LFC_STOP = 2;
    localparam int LFC_LEN_HI = 1;
    localparam logic [7:0] LFC_RESET = 8'h00;

    // ----------------------------------------
    // line_condition_status fields
    // ----------------------------------------
    localparam int LCS_FIFO_ERR = 7;
    localparam int LCS_TX_EMPTY = 6;
    localparam int LCS_THR_EMPTY = 5;
    localparam int LCS_BREAK = 4;
    localparam int LCS_FRAMING = 3;
    localparam int LCS_PARITY = 2;
    localparam int LCS_OVERRUN = 1;
    localparam int LCS_DATA_READY = 0;

    // ----------------------------------------
    // Bit timing, in 16x sample ticks
    // ----------------------------------------
    localparam logic [15:0] DIV_RESET = 16'h0001;
    localparam logic [5:0] TICKS_BIT = 6'h10;     // One bit time
    localparam logic [5:0] TICKS_HALF = 6'h08;    // Mid start bit
    localparam logic [5:0] TICKS_STOP15 = 6'h18;  // 1.5 stop bits
    localparam logic [5:0] TICKS_STOP2 = 6'h20;   // 2 stop bits
    localparam logic [2:0] LEN_BASE = 3'h5;       // Code 00 means five bits

    // Receive entry tag positions above the 8 data bits
    localparam int TAG_BREAK = 10;
    localparam int TAG_FRAMING = 9;
    localparam int TAG_PARITY = 8;

endpackage

/* ulf_uart.sv */
// Purpose: Serial channel with character format control and line status reporting
// Assumes: Single clock, registers on a plain strobe port, read data one cycle later
// Notes:   Divisor sets 16x sample tick period in clocks; zero acts as one
module ulf_uart #(
    parameter int DEPTH = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic [ulf_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Serial line
    input wire logic rxd,
    output logic txd
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulf_tx_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT_HIGH} ulf_rx_t;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------

    // Parity bit for a character under the current format
    function automatic logic par_bit(input logic [7:0] d, input logic [7:0] fmt);
        logic [7:0] m;
        m = d & (8'hff >> (3'h3 - fmt[ulf_pkg::LFC_LEN_HI:0]));
        if (fmt[ulf_pkg::LFC_FORCE_PAR]) begin
            par_bit = ~fmt[ulf_pkg::LFC_EVEN_PAR];
        end else begin
            par_bit = fmt[ulf_pkg::LFC_EVEN_PAR] ? ^m : ~^m;
        end
    endfunction

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rst_sync_reg;
    logic rst_n;

    // Release reset through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ----------------------------------------
    // Registers and decode
    // ----------------------------------------
    logic [7:0] lfc_reg;
    logic [15:0] div_reg;
    logic div_access;
    logic data_wr;
    logic data_rd;
    logic lcs_rd;
    logic [2:0] len_m1;
    logic [5:0] stop_ticks;

    assign div_access = lfc_reg[ulf_pkg::LFC_DIV_ACCESS];
    assign data_wr = reg_wr && reg_addr == ulf_pkg::OFS_DATA && !div_access;
    assign data_rd = reg_rd && reg_addr == ulf_pkg::OFS_DATA && !div_access;
    assign lcs_rd = reg_rd && reg_addr == ulf_pkg::OFS_LCS;
    assign len_m1 = ulf_pkg::LEN_BASE + {1'b0, lfc_reg[ulf_pkg::LFC_LEN_HI:0]} - 3'h1;

    // Stop length in ticks
    always_comb begin
        if (!lfc_reg[ulf_pkg::LFC_STOP]) begin
            stop_ticks = ulf_pkg::TICKS_BIT;
        end else if (lfc_reg[ulf_pkg::LFC_LEN_HI:0] == 2'h0) begin
            stop_ticks = ulf_pkg::TICKS_STOP15;
        end else begin
            stop_ticks = ulf_pkg::TICKS_STOP2;
        end
    end

    // Format and divisor writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lfc_reg <= ulf_pkg::LFC_RESET;
            div_reg <= ulf_pkg::DIV_RESET;
        end else if (reg_wr) begin
            if (reg_addr == ulf_pkg::OFS_LFC) begin
                lfc_reg <= reg_wdata;
            end
            if (div_access && reg_addr == ulf_pkg::OFS_DATA) begin
                div_reg[7:0] <= reg_wdata;
            end
            if (div_access && reg_addr == ulf_pkg::OFS_DIVH) begin
                div_reg[15:8] <= reg_wdata;
            end
        end
    end

    // ----------------------------------------
    // Sample tick
    // ----------------------------------------
    logic [15:0] div_cnt_reg;
    logic tick_reg;

    // One pulse every divisor clocks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else if (div_cnt_reg + 16'h0001 >= div_reg) begin
            div_cnt_reg <= 16'h0000;
            tick_reg <= 1'b1;
        end else begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
            tick_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Transmit FIFO
    // ----------------------------------------
    logic [7:0] tx_mem [DEPTH];
    logic [PW-1:0] tx_wp_reg;
    logic [PW-1:0] tx_rp_reg;
    logic [CW-1:0] tx_cnt_reg;
    logic tx_pop;
    logic tx_push;

    assign tx_push = data_wr && tx_cnt_reg != FULL;

    // Holding FIFO pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_wp_reg <= '0;
            tx_rp_reg <= '0;
            tx_cnt_reg <= '0;
        end else begin
            if (tx_push) begin
                tx_wp_reg <= tx_wp_reg + PW'(1);
            end
            if (tx_pop) begin
                tx_rp_reg <= tx_rp_reg + PW'(1);
            end
            tx_cnt_reg <= tx_cnt_reg + CW'(tx_push) - CW'(tx_pop);
        end
    end

    // Memory write, no reset needed
    always_ff @(posedge clk) begin
        if (tx_push) begin
            tx_mem[tx_wp_reg] <= reg_wdata;
        end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    ulf_tx_t tx_state_reg;
    logic [7:0] tx_sh_reg;
    logic [5:0] tx_tk_reg;
    logic [2:0] tx_bit_reg;
    logic tx_par_reg;
    logic tx_line_reg;

    assign tx_pop = tx_state_reg == TX_IDLE && tx_cnt_reg != '0;

    // Frame sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_reg <= TX_IDLE;
            tx_sh_reg <= 8'h00;
            tx_tk_reg <= 6'h00;
            tx_bit_reg <= 3'h0;
            tx_par_reg <= 1'b0;
            tx_line_reg <= 1'b1;
        end else begin
            unique case (tx_state_reg)
                TX_IDLE: begin
                    tx_line_reg <= 1'b1;
                    tx_tk_reg <= 6'h00;
                    if (tx_pop) begin
                        tx_sh_reg <= tx_mem[tx_rp_reg];
                        tx_par_reg <= par_bit(tx_mem[tx_rp_reg], lfc_reg);
                        tx_line_reg <= 1'b0;
                        tx_state_reg <= TX_START;
                    end
                end
                TX_START, TX_DATA, TX_PAR: begin
                    if (tick_reg) begin
                        tx_tk_reg <= tx_tk_reg + 6'h01;
                        if (tx_tk_reg == ulf_pkg::TICKS_BIT - 6'h01) begin
                            tx_tk_reg <= 6'h00;
                            if (tx_state_reg == TX_START) begin
                                tx_line_reg <= tx_sh_reg[0];
                                tx_bit_reg <= 3'h0;
                                tx_state_reg <= TX_DATA;
                            end else if (tx_state_reg == TX_DATA && tx_bit_reg != len_m1) begin
                                tx_line_reg <= tx_sh_reg[1];
                                tx_sh_reg <= tx_sh_reg >> 1;
                                tx_bit_reg <= tx_bit_reg + 3'h1;
                            end else if (tx_state_reg == TX_DATA && lfc_reg[ulf_pkg::LFC_PAR_EN]) begin
                                tx_line_reg <= tx_par_reg;
                                tx_state_reg <= TX_PAR;
                            end else begin
                                tx_line_reg <= 1'b1;
                                tx_state_reg <= TX_STOP;
                            end
                        end
                    end
                end
                TX_STOP: begin
                    if (tick_reg) begin
                        tx_tk_reg <= tx_tk_reg + 6'h01;
                        if (tx_tk_reg == stop_ticks - 6'h01) begin
                            tx_state_reg <= TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Line driver with break override
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txd <= 1'b1;
        end else begin
            txd <= lfc_reg[ulf_pkg::LFC_BREAK] ? 1'b0 : tx_line_reg;
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    logic [1:0] rx_sync_reg;
    logic rx_in;
    ulf_rx_t rx_state_reg;
    logic [7:0] rx_sh_reg;
    logic [5:0] rx_tk_reg;
    logic [2:0] rx_bit_reg;
    logic rx_pbit_reg;
    logic rx_push_reg;
    logic [10:0] rx_entry_reg;

    // Two-flop input synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sync_reg <= 2'h3;
        end else begin
            rx_sync_reg <= {rx_sync_reg[0], rxd};
        end
    end
    assign rx_in = rx_sync_reg[1];

    // Frame sampler
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_reg <= RX_IDLE;
            rx_sh_reg <= 8'h00;
            rx_tk_reg <= 6'h00;
            rx_bit_reg <= 3'h0;
            rx_pbit_reg <= 1'b0;
            rx_push_reg <= 1'b0;
            rx_entry_reg <= 11'h000;
        end else begin
            rx_push_reg <= 1'b0;
            unique case (rx_state_reg)
                RX_IDLE: begin
                    rx_tk_reg <= 6'h00;
                    if (!rx_in) begin
                        rx_state_reg <= RX_START;
                    end
                end
                RX_START: begin
                    if (tick_reg) begin
                        rx_tk_reg <= rx_tk_reg + 6'h01;
                        if (rx_tk_reg == ulf_pkg::TICKS_HALF - 6'h01) begin
                            rx_tk_reg <= 6'h00;
                            rx_sh_reg <= 8'h00;
                            rx_bit_reg <= 3'h0;
                            rx_pbit_reg <= 1'b0;
                            rx_state_reg <= rx_in ? RX_IDLE : RX_DATA; // False start rejected
                        end
                    end
                end
                RX_DATA, RX_PAR: begin
                    if (tick_reg) begin
                        rx_tk_reg <= rx_tk_reg + 6'h01;
                        if (rx_tk_reg == ulf_pkg::TICKS_BIT - 6'h01) begin
                            rx_tk_reg <= 6'h00;
                            if (rx_state_reg == RX_PAR) begin
                                rx_pbit_reg <= rx_in;
                                rx_state_reg <= RX_STOP;
                            end else begin
                                rx_sh_reg[rx_bit_reg] <= rx_in;
                                rx_bit_reg <= rx_bit_reg + 3'h1;
                                if (rx_bit_reg == len_m1) begin
                                    rx_state_reg <= lfc_reg[ulf_pkg::LFC_PAR_EN] ? RX_PAR : RX_STOP;
                                end
                            end
                        end
                    end
                end
                RX_STOP: begin
                    if (tick_reg) begin
                        rx_tk_reg <= rx_tk_reg + 6'h01;
                        if (rx_tk_reg == ulf_pkg::TICKS_BIT - 6'h01) begin
                            rx_push_reg <= 1'b1;
                            rx_entry_reg[7:0] <= rx_sh_reg;
                            rx_entry_reg[ulf_pkg::TAG_FRAMING] <= !rx_in;
                            rx_entry_reg[ulf_pkg::TAG_BREAK] <= !rx_in && rx_sh_reg == 8'h00 && !rx_pbit_reg;
                            rx_entry_reg[ulf_pkg::TAG_PARITY] <= lfc_reg[ulf_pkg::LFC_PAR_EN]
                                && rx_pbit_reg != par_bit(rx_sh_reg, lfc_reg);
                            rx_state_reg <= rx_in ? RX_IDLE : RX_WAIT_HIGH;
                        end
                    end
                end
                RX_WAIT_HIGH: begin
                    if (rx_in) begin
                        rx_state_reg <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state_reg <= RX_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Receive FIFO with error tags
    // ----------------------------------------
    logic [10:0] rx_mem [DEPTH];
    logic [PW-1:0] rx_wp_reg;
    logic [PW-1:0] rx_rp_reg;
    logic [CW-1:0] rx_cnt_reg;
    logic [CW-1:0] err_cnt_reg;
    logic [10:0] rx_head;
    logic rx_push;
    logic rx_pop;
    logic overrun_reg;

    assign rx_push = rx_push_reg && rx_cnt_reg != FULL;
    assign rx_pop = data_rd && rx_cnt_reg != '0;
    assign rx_head = rx_cnt_reg != '0 ? rx_mem[rx_rp_reg] : 11'h000;

    // Pointers, fill count and count of tagged entries
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_wp_reg <= '0;
            rx_rp_reg <= '0;
            rx_cnt_reg <= '0;
            err_cnt_reg <= '0;
        end else begin
            if (rx_push) begin
                rx_wp_reg <= rx_wp_reg + PW'(1);
            end
            if (rx_pop) begin
                rx_rp_reg <= rx_rp_reg + PW'(1);
            end
            rx_cnt_reg <= rx_cnt_reg + CW'(rx_push) - CW'(rx_pop);
            err_cnt_reg <= err_cnt_reg + CW'(rx_push && |rx_entry_reg[10:8])
                - CW'(rx_pop && |rx_head[10:8]);
        end
    end

    // Memory write, no reset needed
    always_ff @(posedge clk) begin
        if (rx_push) begin
            rx_mem[rx_wp_reg] <= rx_entry_reg;
        end
    end

    // Overrun: a lost character wins over a status-read clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overrun_reg <= 1'b0;
        end else if (rx_push_reg && rx_cnt_reg == FULL) begin
            overrun_reg <= 1'b1;
        end else if (lcs_rd) begin
            overrun_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [7:0] lcs_val;

    assign lcs_val = {err_cnt_reg != '0,
                      tx_cnt_reg == '0 && tx_state_reg == TX_IDLE,
                      tx_cnt_reg == '0,
                      rx_head[ulf_pkg::TAG_BREAK:ulf_pkg::TAG_PARITY],
                      overrun_reg,
                      rx_cnt_reg != '0};

    // Registered read answer, zero for unmapped offsets
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ulf_pkg::OFS_DATA: reg_rdata <= div_access ? div_reg[7:0] : rx_head[7:0];
                ulf_pkg::OFS_DIVH: reg_rdata <= div_access ? div_reg[15:8] : 8'h00;
                ulf_pkg::OFS_LFC: reg_rdata <= lfc_reg;
                ulf_pkg::OFS_LCS: reg_rdata <= lcs_val;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

/* ulf_uart_asserts.sv */
// Purpose: Port-level checks for the serial channel
// Assumes: Divisor high byte is never written
// Notes:   Shadows the format and divisor low registers
module ulf_uart_asserts #(
    parameter int DEPTH = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic [ulf_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Serial line
    input wire logic rxd,
    input wire logic txd
);
    logic [7:0] lfc_reg;
    logic [7:0] dl_reg;
    logic lcs_reg;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // Shadow of format and divisor low as software wrote them
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lfc_reg <= ulf_pkg::LFC_RESET;
            dl_reg <= ulf_pkg::DIV_RESET[7:0];
        end else if (reg_wr && reg_addr == ulf_pkg::OFS_LFC) begin
            lfc_reg <= reg_wdata;
        end else if (reg_wr && reg_addr == ulf_pkg::OFS_DATA && lfc_reg[7]) begin
            dl_reg <= reg_wdata;
        end
    end
    // Marks the cycle that carries status read data
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lcs_reg <= 1'b0;
        end else begin
            lcs_reg <= reg_rd && reg_addr == ulf_pkg::OFS_LCS;
        end
    end
    property p_brk; lfc_reg[6] && $past(lfc_reg[6]) |-> !txd; endproperty
    a_brk: assert property (p_brk) else $error("txd high in break");
    property p_lfc; reg_rd && reg_addr == ulf_pkg::OFS_LFC |=> reg_rdata == lfc_reg; endproperty
    a_lfc: assert property (p_lfc) else $error("format readback wrong");
    property p_dll; reg_rd && reg_addr == ulf_pkg::OFS_DATA && lfc_reg[7] |=> reg_rdata == dl_reg; endproperty
    a_dll: assert property (p_dll) else $error("divisor low readback wrong");
    property p_dh0; reg_rd && reg_addr == ulf_pkg::OFS_DIVH && !lfc_reg[7] |=> reg_rdata == 8'h00; endproperty
    a_dh0: assert property (p_dh0) else $error("divisor high seen while closed");
    property p_b6; lcs_reg && reg_rdata[6] |-> reg_rdata[5]; endproperty
    a_b6: assert property (p_b6) else $error("empty without holding empty");
    property p_tag; lcs_reg && reg_rdata[4:2] != 3'h0 |-> reg_rdata[0]; endproperty
    a_tag: assert property (p_tag) else $error("tag without data");
    property p_fer; lcs_reg && reg_rdata[4:2] != 3'h0 |-> reg_rdata[7]; endproperty
    a_fer: assert property (p_fer) else $error("head error without fifo error");
    property p_idle; lcs_reg && reg_rdata[6] && !lfc_reg[6] && !$past(lfc_reg[6]) |-> txd; endproperty
    a_idle: assert property (p_idle) else $error("txd low while empty");
endmodule

bind ulf_uart ulf_uart_asserts #(.DEPTH(DEPTH)) ulf_uart_asserts_inst (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd));

/* ulf_line_model.sv */
// Purpose: Remote terminal that sends characters and samples the reply
// Assumes: Divisor one, so a bit lasts 16 clocks
// Notes:   Line idles high as through a pull-up
module ulf_line_model (
    // Clock
    input wire logic clk,
    // Serial line
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    int nsamp = 10;
    int nfr = 0;
    time t0 = 0;
    time span = 0;
    logic [11:0] got = 12'h000;
    initial rxd = 1'b1;
    // Send bits LSB first, then idle high long enough to rearm
    task automatic send(input logic [11:0] b, input int nb);
        for (int i = 0; i < nb; i++) begin
            @(posedge clk);
            rxd <= b[i];
            repeat (15) @(posedge clk);
        end
        @(posedge clk);
        rxd <= 1'b1;
        repeat (40) @(posedge clk);
    endtask
    // Time each start edge and sample the frame at mid-bit
    initial begin
        forever begin
            @(negedge txd);
            span = $time - t0;
            t0 = $time;
            got = 12'h000;
            for (int i = 0; i < nsamp; i++) begin
                #(i == 0 ? 320 : 640);
                got[i] = txd;
            end
            nfr++;
        end
    end
endmodule

/* ulf_uart_bench.sv */
// Purpose: Self-checking bench for the serial channel
// Assumes: Divisor one, receive FIFO depth four
// Notes:   Each test task drives the block and judges its answers
module ulf_uart_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic rxd;
    logic txd;
    logic [7:0] rv;
    int err_count = 0;
    int total_checks = 0;
    localparam logic [7:0] FMT [8] = '{8'h00, 8'h07, 8'h0f, 8'h1b, 8'h2a, 8'h3d, 8'h03, 8'h04};
    // Clock at 25 MHz
    always #20 clk = ~clk;
    ulf_uart #(.DEPTH(4)) ulf_uart_inst (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd));
    ulf_line_model ulf_line_model_inst (.clk(clk), .txd(txd), .rxd(rxd));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        rd(a);
        chk(rv, e);
    endtask
    // Expected line bits: start, data, parity, first stop
    function automatic logic [11:0] frame(input logic [7:0] f, input logic [7:0] d);
        int n;
        logic p;
        n = 5 + f[1:0];
        frame = {3'h0, d & (8'hff >> (8 - n)), 1'b0};
        p = ^frame ^ ~f[4];
        if (f[5]) p = ~f[4];
        if (f[3]) frame[n + 1] = p;
        frame[n + 1 + f[3]] = 1'b1;
    endfunction
    // Clocks from one start edge to the next, plus the one idle clock between frames
    function automatic int flen(input logic [7:0] f);
        flen = 16 * (6 + f[1:0] + f[3]) + (f[2] ? (f[1:0] == 2'h0 ? 24 : 32) : 16) + 1;
    endfunction
    task automatic t_reset;
        rdc(ulf_pkg::OFS_LFC, ulf_pkg::LFC_RESET);
        rdc(ulf_pkg::OFS_LCS, 8'h60);
        rdc(ulf_pkg::OFS_DIVH, 8'h00);
        rdc(3'h2, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_div;
        wr(ulf_pkg::OFS_LFC, 8'h83);
        wr(ulf_pkg::OFS_DATA, 8'h34);
        rdc(ulf_pkg::OFS_DATA, 8'h34);
        rdc(ulf_pkg::OFS_DIVH, ulf_pkg::DIV_RESET[15:8]);
        wr(ulf_pkg::OFS_DATA, 8'h01);
        wr(ulf_pkg::OFS_LFC, 8'h03);
        rdc(ulf_pkg::OFS_LCS, 8'h60);
        $display("t_div done");
    endtask
    task automatic t_fmt;
        logic [7:0] f;
        logic [7:0] d;
        int k;
        for (int j = 0; j < 8; j++) begin
            f = FMT[j];
            d = 8'h4d ^ 8'(j);
            ulf_line_model_inst.nsamp = 7 + f[1:0] + f[3];
            wr(ulf_pkg::OFS_LFC, f);
            k = ulf_line_model_inst.nfr;
            wr(ulf_pkg::OFS_DATA, 8'hb4);
            wr(ulf_pkg::OFS_DATA, d);
            rd(ulf_pkg::OFS_LCS);
            chk(rv & 8'h60, 8'h00);
            for (int i = 0; i < 900 && ulf_line_model_inst.nfr < k + 2; i++) @(posedge clk);
            chk(ulf_line_model_inst.got, frame(f, d));
            chk(16'(ulf_line_model_inst.span / 40), 16'(flen(f)));
            rv = 8'h00;
            for (int i = 0; i < 300 && !rv[6]; i++) rd(ulf_pkg::OFS_LCS);
            chk(rv, 8'h60);
            ulf_line_model_inst.send(frame(f, d), 7 + f[1:0] + f[3]);
            rdc(ulf_pkg::OFS_LCS, 8'h61);
            rdc(ulf_pkg::OFS_DATA, d & (8'hff >> (3 - f[1:0])));
        end
        $display("t_fmt done");
    endtask
    task automatic t_err;
        wr(ulf_pkg::OFS_LFC, 8'h1b);
        ulf_line_model_inst.send(frame(8'h1b, 8'h3c) ^ 12'h200, 11);
        ulf_line_model_inst.send(frame(8'h1b, 8'h5a) ^ 12'h400, 11);
        ulf_line_model_inst.send(12'h000, 12);
        rdc(ulf_pkg::OFS_LCS, 8'he5);
        rdc(ulf_pkg::OFS_DATA, 8'h3c);
        rdc(ulf_pkg::OFS_LCS, 8'he9);
        rdc(ulf_pkg::OFS_DATA, 8'h5a);
        rdc(ulf_pkg::OFS_LCS, 8'hf9);
        rdc(ulf_pkg::OFS_LCS, 8'hf9);
        rdc(ulf_pkg::OFS_DATA, 8'h00);
        rdc(ulf_pkg::OFS_LCS, 8'h60);
        $display("t_err done");
    endtask
    task automatic t_ovr;
        wr(ulf_pkg::OFS_LFC, 8'h00);
        for (int i = 1; i < 6; i++) ulf_line_model_inst.send(frame(8'h00, 8'(i)), 7);
        rdc(ulf_pkg::OFS_LCS, 8'h63);
        rdc(ulf_pkg::OFS_LCS, 8'h61);
        for (int i = 1; i < 5; i++) rdc(ulf_pkg::OFS_DATA, 8'(i));
        rdc(ulf_pkg::OFS_LCS, 8'h60);
        $display("t_ovr done");
    endtask
    task automatic t_brk;
        wr(ulf_pkg::OFS_LFC, 8'h43);
        repeat (200) @(posedge clk);
        chk(txd, 1'b0);
        wr(ulf_pkg::OFS_LFC, 8'h03);
        @(posedge clk);
        #1 chk(txd, 1'b1);
        $display("t_brk done");
    endtask
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Reset, then the tests in turn
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_div;
        t_fmt;
        t_err;
        t_ovr;
        t_brk;
        complete_run;
    end
    // Cuts a hang short
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        complete_run;
    end
endmodule
